// ---- ebw_cfg.svh ----
// constants for the external bus wait and bank control block
`ifndef EBW_CFG_SVH
`define EBW_CFG_SVH
// memory-mapped register offsets
`define EBW_OFS_WAIT_STATE 7'h28
`define EBW_OFS_BANK_SWITCH 7'h29
`define EBW_OFS_WAIT_MULT 7'h2b
// wait state register fields
`define EBW_WS_XPA_BIT 15
`define EBW_WS_IO_LSB 12
`define EBW_WS_DHI_LSB 9
`define EBW_WS_DLO_LSB 6
`define EBW_WS_PHI_LSB 3
`define EBW_WS_PLO_LSB 0
`define EBW_WS_RESET 16'h7fff
// bank switch register fields
`define EBW_BS_CMP_LSB 12
`define EBW_BS_TURN_BIT 11
`define EBW_BS_HBH_BIT 2
`define EBW_BS_BH_BIT 1
`define EBW_BS_OFF_BIT 0
`define EBW_BS_WMASK 16'hf807
`define EBW_BS_RESET 16'hf800
// wait multiplier register
`define EBW_WM_WMASK 16'h0001
`define EBW_WM_RESET 16'h0000
// extra cycles for bank or turnaround
`define EBW_EXTRA_CYCLES 5'h01
`endif

// ---- ebw_pkg.sv ----
// types for the external bus wait and bank control block
package ebw_pkg;
    typedef enum logic [1:0] {
        EBW_SP_PROG = 2'b00,
        EBW_SP_DATA = 2'b01,
        EBW_SP_IO = 2'b10
    } ebw_space_t;

    typedef struct packed {
        logic valid;
        ebw_space_t space;
        logic write;
        logic [19:0] addr;
        logic [15:0] wdata;
    } ebw_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic data_oe;
        logic prog_strobe_n;
        logic data_strobe_n;
        logic io_space_strobe_n;
        logic rw;
        logic mem_strobe_n;
    } ebw_pins_t;

    typedef enum logic [1:0] {
        EBW_ST_IDLE = 2'b00,
        EBW_ST_EXTRA = 2'b01,
        EBW_ST_WAIT = 2'b10,
        EBW_ST_DONE = 2'b11
    } ebw_state_t;
endpackage

// ---- ebw_sync.sv ----
// three flop input synchroniser with agreement filter
`timescale 1ns/1ns
module ebw_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule

// ---- ebw_bus_holder.sv ----
// bus holder keeper for an undriven bus
`timescale 1ns/1ns
module ebw_bus_holder #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic driven,
    input wire logic [W-1:0] bus_in,
    output logic [W-1:0] keep_out,
    output logic keep_oe
);
    logic [W-1:0] last_q;
    logic oe_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_q <= '0;
            oe_q <= 1'b0;
        end else begin
            if (driven) begin
                last_q <= bus_in;
            end
            oe_q <= enable && !driven;
        end
    end

    assign keep_out = last_q;
    assign keep_oe = oe_q;
endmodule

// ---- ebw_ctrl.sv ----
// external bus wait state, bank switch and bus-off control
// Behaviour
// RULE1 - with the multiplier bit clear base wait counts are used as is, set doubles them up to 14.
// RULE2 - reserved bits of the multiplier and bank switch registers read zero and ignore writes.
// RULE3 - one extra cycle is inserted when consecutive accesses cross a bank within program or data space.
// RULE4 - one extra cycle is inserted when accesses move from data space into program space.
// RULE5 - the 4-bit compare mask picks which of the top four address bits detect a bank change.
// RULE6 - with the turnaround bit set a program read then data read, or the reverse, gets one extra cycle.
// RULE7 - with host bus hold set the 8-bit host data bus keeps its last level while undriven.
// RULE8 - with data bus hold set the 16-bit data bus keeps its last level while undriven.
// RULE9 - with bus-off set the current cycle finishes and then address, data and strobes go inactive.
// RULE10 - while bus-off is set writes to the rom, mode, overlay and hold mode bits are blocked.
// RULE11 - a 64K I/O space is reached only by the port read and port write instructions.
// RULE12 - the I/O space strobe is asserted during every port read or write.
// RULE13 - at reset every external access gets seven wait states.
// RULE14 - five 3-bit fields give wait counts for I/O, upper data, lower data, upper and lower program.
// RULE15 - devices needing more waits extend the cycle with the ready input.
// RULE16 - bank and turnaround cycles add to the multiplied wait states, all in machine cycles.
// RULE17 - the previous access space and masked high address bits are latched for change detection.
`timescale 1ns/1ns
`include "ebw_cfg.svh"
module ebw_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic mmr_we,
    input wire logic mmr_re,
    input wire logic [6:0] mmr_addr,
    input wire logic [15:0] mmr_wdata,
    output logic [15:0] mmr_rdata,
    input wire ebw_pkg::ebw_req_t req,
    output logic req_ready,
    output logic req_done,
    output logic [15:0] req_rdata,
    input wire logic [3:0] mode_wr_en,
    output logic [3:0] mode_wr_allow,
    input wire logic ready_pin,
    output ebw_pkg::ebw_pins_t pins,
    input wire logic [15:0] data_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_data_driven,
    output logic [7:0] host_data_keep,
    output logic host_data_keep_oe,
    output logic [15:0] data_keep,
    output logic data_keep_oe,
    output logic bus_off_status
);
    // ==================================================
    // registers
    logic [15:0] wait_state_register_q;
    logic wait_multiplier_bit_q;
    logic [3:0] bank_compare_mask_q;
    logic prog_data_turnaround_q;
    logic host_bus_hold_q;
    logic data_bus_hold_q;
    logic external_bus_off_q;
    wire [15:0] bank_switch_control;
    wire [15:0] wait_multiplier_control;
    wire sel_ws = mmr_addr == `EBW_OFS_WAIT_STATE;
    wire sel_bs = mmr_addr == `EBW_OFS_BANK_SWITCH;
    wire sel_wm = mmr_addr == `EBW_OFS_WAIT_MULT;

    // RULE2 reserved read zero
    assign bank_switch_control = {bank_compare_mask_q, prog_data_turnaround_q, 8'h00,
                                  host_bus_hold_q, data_bus_hold_q, external_bus_off_q};
    assign wait_multiplier_control = {15'h0000, wait_multiplier_bit_q};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // RULE13 seven waits everywhere
            wait_state_register_q <= `EBW_WS_RESET;
            wait_multiplier_bit_q <= 1'b0;
            bank_compare_mask_q <= 4'hf;
            prog_data_turnaround_q <= 1'b1;
            host_bus_hold_q <= 1'b0;
            data_bus_hold_q <= 1'b0;
            external_bus_off_q <= 1'b0;
        end else if (mmr_we) begin
            if (sel_ws) begin
                wait_state_register_q <= mmr_wdata;
            end
            // RULE2 reserved writes ignored
            if (sel_wm) begin
                wait_multiplier_bit_q <= mmr_wdata[0];
            end
            if (sel_bs) begin
                bank_compare_mask_q <= mmr_wdata[15:12];
                prog_data_turnaround_q <= mmr_wdata[`EBW_BS_TURN_BIT];
                host_bus_hold_q <= mmr_wdata[`EBW_BS_HBH_BIT];
                data_bus_hold_q <= mmr_wdata[`EBW_BS_BH_BIT];
                external_bus_off_q <= mmr_wdata[`EBW_BS_OFF_BIT];
            end
        end
    end

    logic [15:0] rdata_q;
    wire [15:0] rdata_d = sel_ws ? wait_state_register_q :
                          sel_bs ? bank_switch_control :
                          sel_wm ? wait_multiplier_control : 16'h0000;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else if (mmr_re) begin
            rdata_q <= rdata_d;
        end
    end
    assign mmr_rdata = rdata_q;

    // ==================================================
    // mode bit write guard
    logic [3:0] allow_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            allow_q <= 4'h0;
        end else begin
            // RULE10 block mode writes
            allow_q <= external_bus_off_q ? 4'h0 : mode_wr_en;
        end
    end
    assign mode_wr_allow = allow_q;

    // ==================================================
    // wait count selection
    function automatic logic [2:0] field_sel(input logic [15:0] ws, input ebw_pkg::ebw_space_t sp,
                                             input logic [19:0] a);
        logic [2:0] f;
        f = ws[2:0];
        case (sp)
            ebw_pkg::EBW_SP_IO: f = ws[14:12];
            ebw_pkg::EBW_SP_DATA: f = a[15] ? ws[11:9] : ws[8:6];
            default: f = (!ws[`EBW_WS_XPA_BIT] && a[15]) ? ws[5:3] : ws[2:0];
        endcase
        return f;
    endfunction

    // RULE14 per-range field
    wire [2:0] base_waits = field_sel(wait_state_register_q, req.space, req.addr);
    // RULE1 optional doubling
    wire [4:0] mult_waits = wait_multiplier_bit_q ? {1'b0, base_waits, 1'b0} : {2'b00, base_waits};

    // ==================================================
    // bank and turnaround detection
    logic prev_valid_q;
    ebw_pkg::ebw_space_t prev_space_q;
    logic prev_write_q;
    logic [3:0] prev_bank_q;
    // RULE5 masked high bits
    wire [3:0] cur_bank = req.addr[15:12] & bank_compare_mask_q;
    wire same_space = prev_space_q == req.space;
    // RULE3 bank cross
    wire bank_cross = prev_valid_q && same_space && req.space != ebw_pkg::EBW_SP_IO && prev_bank_q != cur_bank;
    // RULE4 data into program
    wire data_to_prog = prev_valid_q && prev_space_q == ebw_pkg::EBW_SP_DATA && req.space == ebw_pkg::EBW_SP_PROG;
    // RULE6 read turnaround
    wire turnaround = prog_data_turnaround_q && prev_valid_q && !prev_write_q && !req.write &&
                      ((prev_space_q == ebw_pkg::EBW_SP_DATA && req.space == ebw_pkg::EBW_SP_PROG) ||
                       (prev_space_q == ebw_pkg::EBW_SP_PROG && req.space == ebw_pkg::EBW_SP_DATA));
    wire need_extra = bank_cross || data_to_prog || turnaround;

    // ==================================================
    // bus cycle sequencer
    ebw_pkg::ebw_state_t state_q;
    logic [4:0] cnt_q;
    ebw_pkg::ebw_req_t cur_q;
    logic done_q;
    logic [15:0] rd_q;
    logic off_q;
    logic ready_s;
    ebw_pkg::ebw_pins_t pins_q;
    wire start = state_q == ebw_pkg::EBW_ST_IDLE && req.valid && !external_bus_off_q;

    ebw_sync u_ready_sync (
        .clk(clk),
        .resetn(resetn),
        .din(ready_pin),
        .dout(ready_s)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ebw_pkg::EBW_ST_IDLE;
            cnt_q <= 5'h00;
            cur_q <= '0;
            done_q <= 1'b0;
            rd_q <= 16'h0000;
            prev_valid_q <= 1'b0;
            prev_space_q <= ebw_pkg::EBW_SP_PROG;
            prev_write_q <= 1'b0;
            prev_bank_q <= 4'h0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ebw_pkg::EBW_ST_IDLE: begin
                    if (start) begin
                        cur_q <= req;
                        cnt_q <= mult_waits;
                        // RULE17 latch previous access
                        prev_valid_q <= 1'b1;
                        prev_space_q <= req.space;
                        prev_write_q <= req.write;
                        prev_bank_q <= cur_bank;
                        // RULE16 extra before waits
                        state_q <= need_extra ? ebw_pkg::EBW_ST_EXTRA : ebw_pkg::EBW_ST_WAIT;
                    end
                end
                ebw_pkg::EBW_ST_EXTRA: begin
                    state_q <= ebw_pkg::EBW_ST_WAIT;
                end
                ebw_pkg::EBW_ST_WAIT: begin
                    // waits count once the strobe is out on the pins
                    if (pins_q.mem_strobe_n) begin
                        cnt_q <= cnt_q;
                    end else if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    // RULE15 ready extends cycle
                    end else if (ready_s) begin
                        rd_q <= data_in;
                        state_q <= ebw_pkg::EBW_ST_DONE;
                    end
                end
                ebw_pkg::EBW_ST_DONE: begin
                    done_q <= 1'b1;
                    state_q <= ebw_pkg::EBW_ST_IDLE;
                end
                default: state_q <= ebw_pkg::EBW_ST_IDLE;
            endcase
        end
    end

    assign req_done = done_q;
    assign req_rdata = rd_q;
    logic ready_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b0;
            off_q <= 1'b0;
        end else begin
            ready_q <= state_q == ebw_pkg::EBW_ST_IDLE && !start && !external_bus_off_q;
            // RULE9 off after current cycle
            off_q <= external_bus_off_q && state_q == ebw_pkg::EBW_ST_IDLE;
        end
    end
    assign req_ready = ready_q;
    assign bus_off_status = off_q;

    // ==================================================
    // pin drive
    wire active = state_q == ebw_pkg::EBW_ST_WAIT || state_q == ebw_pkg::EBW_ST_EXTRA;
    wire strobe_on = state_q == ebw_pkg::EBW_ST_WAIT;
    ebw_pkg::ebw_pins_t pins_d;
    always_comb begin
        pins_d = '0;
        pins_d.prog_strobe_n = 1'b1;
        pins_d.data_strobe_n = 1'b1;
        pins_d.io_space_strobe_n = 1'b1;
        pins_d.mem_strobe_n = 1'b1;
        pins_d.rw = 1'b1;
        if (active) begin
            // RULE11 16-bit port address
            pins_d.addr = cur_q.addr[15:0];
            pins_d.data = cur_q.wdata;
            pins_d.data_oe = cur_q.write;
            pins_d.rw = !cur_q.write;
            pins_d.prog_strobe_n = !(cur_q.space == ebw_pkg::EBW_SP_PROG);
            pins_d.data_strobe_n = !(cur_q.space == ebw_pkg::EBW_SP_DATA);
            // RULE12 io strobe on ports
            pins_d.io_space_strobe_n = !(cur_q.space == ebw_pkg::EBW_SP_IO);
            pins_d.mem_strobe_n = !strobe_on;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_q <= '0;
            pins_q.prog_strobe_n <= 1'b1;
            pins_q.data_strobe_n <= 1'b1;
            pins_q.io_space_strobe_n <= 1'b1;
            pins_q.mem_strobe_n <= 1'b1;
            pins_q.rw <= 1'b1;
        end else begin
            pins_q <= pins_d;
        end
    end
    assign pins = pins_q;

    // ==================================================
    // bus holders
    // bus driven by us or by the strobed device in the next cycle
    wire data_driven = pins_d.data_oe || !pins_d.mem_strobe_n;
    // RULE8 data bus keeper
    ebw_bus_holder #(.W(16)) u_data_hold (
        .clk(clk),
        .resetn(resetn),
        .enable(data_bus_hold_q),
        .driven(data_driven),
        .bus_in(data_in),
        .keep_out(data_keep),
        .keep_oe(data_keep_oe)
    );
    // RULE7 host bus keeper
    ebw_bus_holder #(.W(8)) u_host_hold (
        .clk(clk),
        .resetn(resetn),
        .enable(host_bus_hold_q),
        .driven(host_data_driven),
        .bus_in(host_data_in),
        .keep_out(host_data_keep),
        .keep_oe(host_data_keep_oe)
    );
endmodule

// ---- ebw_ctrl_properties.sv ----
// concurrent checks on the ports of the wait and bank control block
`timescale 1ns/1ns
`include "ebw_cfg.svh"
module ebw_ctrl_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic mmr_re,
    input wire logic [6:0] mmr_addr,
    input wire logic [15:0] mmr_rdata,
    input wire ebw_pkg::ebw_req_t req,
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic [3:0] mode_wr_allow,
    input wire ebw_pkg::ebw_pins_t pins,
    input wire logic data_keep_oe,
    input wire logic bus_off_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========
    // properties
    property p_off_ready; bus_off_status |-> !req_ready; endproperty
    a_off_ready: assert property (p_off_ready) else $error("ready while off");
    property p_off_pins; bus_off_status |-> pins.mem_strobe_n && pins.io_space_strobe_n && !pins.data_oe; endproperty
    a_off_pins: assert property (p_off_pins) else $error("bus active while off");
    property p_off_mode; bus_off_status && $past(bus_off_status) |-> mode_wr_allow == 4'h0; endproperty
    a_off_mode: assert property (p_off_mode) else $error("mode write allowed while off");
    property p_io_excl; !pins.io_space_strobe_n |-> pins.prog_strobe_n && pins.data_strobe_n; endproperty
    a_io_excl: assert property (p_io_excl) else $error("io strobe with memory strobe");
    property p_wm_res; mmr_re && mmr_addr == `EBW_OFS_WAIT_MULT |=> mmr_rdata[15:1] == 15'h0000; endproperty
    a_wm_res: assert property (p_wm_res) else $error("multiplier reserved bits set");
    property p_bs_res; mmr_re && mmr_addr == `EBW_OFS_BANK_SWITCH |=> mmr_rdata[10:3] == 8'h00; endproperty
    a_bs_res: assert property (p_bs_res) else $error("bank reserved bits set");
    property p_unmapped; mmr_re && mmr_addr == 7'h30 |=> mmr_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_done_pulse; req_done |=> !req_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_take; req.valid && req_ready |=> !req_done ##1 !req_done; endproperty
    a_take: assert property (p_take) else $error("access finished too soon");
    property p_keep; data_keep_oe |-> !pins.data_oe; endproperty
    a_keep: assert property (p_keep) else $error("keeper fights driver");
endmodule
bind ebw_ctrl ebw_ctrl_chk u_ebw_ctrl_chk (.clk(clk), .resetn(resetn), .mmr_re(mmr_re), .mmr_addr(mmr_addr),
    .mmr_rdata(mmr_rdata), .req(req), .req_ready(req_ready), .req_done(req_done), .mode_wr_allow(mode_wr_allow),
    .pins(pins), .data_keep_oe(data_keep_oe), .bus_off_status(bus_off_status));

// ---- ebw_mem_model.sv ----
// external memory and port model on the parallel bus
`timescale 1ns/1ns
module ebw_mem_model (
    input wire logic clk,
    input wire ebw_pkg::ebw_pins_t pins,
    input wire logic [15:0] data_keep,
    input wire logic data_keep_oe,
    input int slow,
    output logic [15:0] data_in,
    output logic ready_pin
);
    logic [15:0] last_q = 16'h0000;
    logic sel;
    int cnt = 0;
    assign sel = pins.rw && (!pins.mem_strobe_n || !pins.io_space_strobe_n);
    assign data_in = pins.data_oe ? pins.data : sel ? (pins.addr ^ 16'h5a5a) : data_keep_oe ? data_keep : ~last_q;
    assign ready_pin = (cnt >= slow);
    always @(posedge clk) begin
        last_q <= data_in;
        cnt <= (pins.mem_strobe_n && pins.io_space_strobe_n) ? 0 : cnt + 1;
    end
endmodule

// ---- ebw_ctrl_test.sv ----
// testbench for the wait and bank control block
`timescale 1ns/1ns
module ebw_ctrl_test;
    logic clk = 0, resetn = 0, mmr_we = 0, mmr_re = 0, host_data_driven = 1, ready_pin, req_ready, req_done;
    logic host_data_keep_oe, data_keep_oe, bus_off_status;
    logic [6:0] mmr_addr = 7'h00;
    logic [15:0] mmr_wdata = 16'h0000, mmr_rdata, req_rdata, data_in, data_keep, rd;
    logic [3:0] mode_wr_en = 4'hf, mode_wr_allow;
    logic [7:0] host_val = 8'h00, host_data_in, host_data_keep;
    logic [71:0] r;
    ebw_pkg::ebw_req_t req = '0;
    ebw_pkg::ebw_pins_t pins;
    int num_errors = 0, tests_run = 0, slow = 0, l0, lat;
    // rows: wait, bank, mult, space, write, addr, extra cycles
    logic [71:0] rows [19] = '{72'h0005_0000_0_0_0_00010_05, 72'h0005_0000_1_0_0_00010_0a,
        72'h0007_0000_1_0_0_00010_0e, 72'h0038_0000_0_0_0_08000_07, 72'h3000_0000_0_2_0_00020_03,
        72'h0400_0000_0_1_0_08000_02, 72'h0080_0000_0_1_0_00100_02, 72'h0000_f000_0_0_0_00100_01,
        72'h0000_f000_0_0_0_01100_01, 72'h0000_f000_0_0_0_01200_00, 72'h0000_f000_0_1_1_02000_00,
        72'h0000_f000_0_1_1_03000_01, 72'h0000_8000_0_1_1_0b000_01, 72'h0000_8000_0_1_1_08000_00,
        72'h0000_0000_0_0_0_08000_01, 72'h0000_0800_0_1_0_00000_01, 72'h0000_0800_0_1_0_00004_00,
        72'h00c0_f000_0_1_0_01000_04, 72'h0000_0000_0_2_1_00030_00};
    always #50 clk = ~clk;
    assign host_data_in = host_data_driven ? host_val : host_data_keep_oe ? host_data_keep : ~host_val;
    ebw_ctrl u_ebw_ctrl (.clk(clk), .resetn(resetn), .mmr_we(mmr_we), .mmr_re(mmr_re), .mmr_addr(mmr_addr),
        .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata), .req(req), .req_ready(req_ready), .req_done(req_done),
        .req_rdata(req_rdata), .mode_wr_en(mode_wr_en), .mode_wr_allow(mode_wr_allow), .ready_pin(ready_pin),
        .pins(pins), .data_in(data_in), .host_data_in(host_data_in), .host_data_driven(host_data_driven),
        .host_data_keep(host_data_keep), .host_data_keep_oe(host_data_keep_oe), .data_keep(data_keep),
        .data_keep_oe(data_keep_oe), .bus_off_status(bus_off_status));
    ebw_mem_model u_ebw_mem_model (.clk(clk), .pins(pins), .data_keep(data_keep), .data_keep_oe(data_keep_oe),
        .slow(slow), .data_in(data_in), .ready_pin(ready_pin));
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        mmr_we = 1;
        mmr_addr = a;
        mmr_wdata = d;
        @(negedge clk);
        mmr_we = 0;
    endtask
    task automatic rdr(input logic [6:0] a, output logic [15:0] d);
        @(negedge clk);
        mmr_re = 1;
        mmr_addr = a;
        @(negedge clk);
        mmr_re = 0;
        d = mmr_rdata;
    endtask
    task automatic acc(input logic [1:0] sp, input logic w, input logic [19:0] a, output int n);
        int k;
        k = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        req = {1'b1, ebw_pkg::ebw_space_t'(sp), w, a, ~a[15:0]};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (req_done !== 1'b1 && n < 200);
        req.valid = 0;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    // ==========
    // tests
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1;
        repeat (2) @(negedge clk);
        rdr(7'h28, rd); check(rd, 16'h7fff);
        rdr(7'h29, rd); check(rd, 16'hf800);
        rdr(7'h2b, rd); check(rd, 16'h0000);
        wr(7'h29, 16'hfffe); rdr(7'h29, rd); check(rd, 16'hf806);
        wr(7'h2b, 16'hffff); rdr(7'h2b, rd); check(rd, 16'h0001);
        rdr(7'h30, rd); check(rd, 16'h0000);
        check(mode_wr_allow, 4'hf);
        $display("test registers done");
        wr(7'h28, 16'h0000); wr(7'h29, 16'h0000); wr(7'h2b, 16'h0000);
        acc(2'd0, 0, 20'h00000, l0);
        acc(2'd0, 0, 20'h00004, lat); check(lat, l0);
        check(req_rdata, 16'h0004 ^ 16'h5a5a);
        foreach (rows[i]) begin
            r = rows[i];
            wr(7'h28, r[71:56]); wr(7'h29, r[55:40]); wr(7'h2b, {12'h000, r[39:36]});
            acc(r[33:32], r[28], r[27:8], lat);
            check(lat, l0 + r[7:0]);
            if (!r[28]) check(req_rdata, r[23:8] ^ 16'h5a5a);
        end
        wr(7'h28, 16'h0000); wr(7'h29, 16'h0000);
        slow = 6;
        repeat (4) @(negedge clk);
        acc(2'd0, 0, 20'h00000, lat); check(lat > l0, 1);
        slow = 0;
        $display("test access done");
        wr(7'h29, 16'h0006);
        acc(2'd1, 0, 20'h00200, lat);
        repeat (4) @(negedge clk);
        check(data_keep_oe, 1); check(data_keep, 16'h0200 ^ 16'h5a5a);
        host_val = 8'ha5;
        repeat (4) @(negedge clk);
        host_data_driven = 0;
        repeat (4) @(negedge clk);
        check(host_data_keep_oe, 1); check(host_data_keep, 8'ha5);
        wr(7'h29, 16'h0000);
        repeat (4) @(negedge clk);
        check(data_keep_oe, 0); check(host_data_keep_oe, 0);
        host_data_driven = 1;
        $display("test hold done");
        wr(7'h28, 16'h0007);
        fork
            acc(2'd0, 0, 20'h00010, lat);
            begin
                repeat (4) @(negedge clk);
                wr(7'h29, 16'h0001);
            end
        join
        check(lat, l0 + 8); check(req_rdata, 16'h0010 ^ 16'h5a5a);
        repeat (3) @(negedge clk);
        check(bus_off_status, 1); check(req_ready, 0); check(mode_wr_allow, 4'h0);
        wr(7'h29, 16'h0000);
        repeat (3) @(negedge clk);
        check(bus_off_status, 0); check(req_ready, 1); check(mode_wr_allow, 4'hf);
        $display("test bus off done");
        give_verdict();
    end
endmodule
